// *** logic/osc_consts.svh ***
// Offsets, field positions, reset values and timing counts of the clock control block
`ifndef OSC_CONSTS_SVH
`define OSC_CONSTS_SVH
`define TRIM_REG_ADDR      12'h000
`define CTRL_REG_ADDR      12'h004
`define STAT_REG_ADDR      12'h008
`define TRIM_RESET         8'h00
`define CTRL_RESET         8'h40
`define TRIM_SRC_BIT       7
`define TRIM_PLL_BIT       6
`define CODE_HS_PLL        4'h6
`define CODE_INT_ONE       4'h9
`define CODE_INT_TWO       4'h8
`define CODE_EC            4'hc
`define CODE_EC_IO         4'hd
`define CODE_RC            4'hb
`define CODE_RC_IO         4'h7
`define INTERNAL_FREQ_SELECT_8M            3'h7
`define INTERNAL_FREQ_SELECT_4M            3'h6
`define INTERNAL_FREQ_SELECT_31K           3'h0
`define APPLY_DELAY_CYC    4'h7
`define SETTLE_TIME_US     1000
`define SETTLE_CYC         ((`SETTLE_TIME_US * 200) - 1)
`endif

// *** logic/osc_ctrl.sv ***
// Oscillator mode decode, multiplier gating and internal oscillator trim
//
// Operation
// - External clock modes run at once, no start-up wait after reset or wake.
// - External clock and RC modes drive pin b with system clock over four; the code enables pin b and drives it low instead.
// - Pin-reuse external and RC modes turn pin b into port A bit six.
// - Fast crystal x4 mode multiplies crystal up to 10 MHz by four.
// - In fast crystal x4 mode the software multiplier enable does nothing.
// - Crystal multiplier only with configuration code 0110.
// - Fast source gives 8 MHz directly and feeds postscaler 31 kHz to 4 MHz.
// - Fast source enabled when selected frequency is 125 kHz to 8 MHz.
// - Slow RC runs when selected or when timer, monitor, watchdog, two-speed on.
// - Internal frequency chosen by the internal frequency select field.
// - Internal mode one: pin b gives clock over four (the code enables pin b and drives it low instead), pin a is bit seven.
// - Internal mode two: pin a is bit seven, pin b is bit six.
// - Trim change applied within 8 cycles, settles within 1 ms, no stall.
// - No completion flag for a trim change.
// - Trim changes only the fast source, never the slow RC.
// - Software multiplier only with internal primary codes 1001 or 1000.
// - Internal multiplier only with select 111 or 110.
// - Multiplier enable forced zero and unsettable where unavailable.
// - Software multiplier multiplies internal clock by four, up to 32 MHz.
// - Register: source select bit 7, enable bit 6, bit 5 zero, trim 4..0.
// - Source select one uses fast source over 256; zero uses slow RC.
// - Trim is signed two's complement, 01111 max, 00000 centre, 10000 min.
// - Source select acts only when frequency select is 000.
//
// Chosen here: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`include "osc_consts.svh"
module osc_ctrl
	import osc_pkg::*;
(
	input  wire logic        ref_clk,
	input  wire logic        reset_n,
	input  wire logic [11:0] paddr,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic [3:0]  osc_config_field,
	input  wire logic        feature_timer_en,
	input  wire logic        feature_monitor_en,
	input  wire logic        feature_watchdog_en,
	input  wire logic        feature_two_speed_en,
	input  wire logic        gen_period_end,
	input  wire logic        port_a_six_out,
	input  wire logic        port_a_six_oe,
	input  wire logic        port_a_seven_out,
	input  wire logic        port_a_seven_oe,
	input  wire logic        osc_pin_b_in,
	output logic             osc_pin_b_out,
	output logic             osc_pin_b_oe,
	output logic             osc_pin_a_out,
	output logic             osc_pin_a_oe,
	output logic             port_a_six_in,
	output logic             start_wait_skip,
	output logic             crystal_x4_on,
	output logic             internal_x4_on,
	output logic             fast_internal_source_on,
	output logic             slow_internal_rc_on,
	output logic             low_freq_from_fast,
	output logic [2:0]       postscale_tap,
	output logic [4:0]       gen_trim,
	output logic             settling
);

	// ************************************************************
	// Register bus
	// ************************************************************
	trim_type    trim_r;
	logic [7:0]  ctrl_r;
	logic        wr_ack_r;
	logic [31:0] rdata_nxt;
	wire         access     = psel & penable;
	wire         hit_trim   = paddr == `TRIM_REG_ADDR;
	wire         hit_ctrl   = paddr == `CTRL_REG_ADDR;
	wire         hit_stat   = paddr == `STAT_REG_ADDR;
	wire         unmapped   = !(hit_trim | hit_ctrl | hit_stat);
	wire         wr_trim    = access & pwrite & hit_trim & !pready;
	wire         wr_ctrl    = access & pwrite & hit_ctrl & !pready;
	wire [2:0]   int_sel    = ctrl_r[6:4];

	// ************************************************************
	// Mode decode
	// ************************************************************
	function automatic logic is_int_primary(input logic [3:0] code);
		return code == `CODE_INT_ONE || code == `CODE_INT_TWO;
	endfunction

	wire mode_ec       = osc_config_field == `CODE_EC;
	wire mode_ec_io    = osc_config_field == `CODE_EC_IO;
	wire mode_rc       = osc_config_field == `CODE_RC;
	wire mode_rc_io    = osc_config_field == `CODE_RC_IO;
	wire mode_int_one  = osc_config_field == `CODE_INT_ONE;
	wire mode_int_two  = osc_config_field == `CODE_INT_TWO;
	wire mode_x4       = osc_config_field == `CODE_HS_PLL;
	wire pll_allowed   = is_int_primary(osc_config_field);
	wire freq_ok       = int_sel == `INTERNAL_FREQ_SELECT_8M || int_sel == `INTERNAL_FREQ_SELECT_4M;
	wire int_is_clock  = pll_allowed;
	wire pin_b_clock   = mode_ec | mode_rc | mode_int_one;
	wire pin_b_io      = mode_ec_io | mode_rc_io | mode_int_two;
	wire pin_a_io      = mode_int_one | mode_int_two;

	// Write data to trim register, multiplier enable masked when unavailable
	trim_type trim_nxt;
	assign trim_nxt.src_sel = pwdata[`TRIM_SRC_BIT];
	assign trim_nxt.pll_en  = pwdata[`TRIM_PLL_BIT] & pll_allowed;
	assign trim_nxt.trim    = pwdata[4:0];

	// ************************************************************
	// Trim apply sequencing
	// ************************************************************
	apply_type   st_r;
	logic [3:0]  dly_r;
	logic [17:0] settle_r;
	trim_type    gen_r;

	// ************************************************************
	// Pin input synchroniser
	// ************************************************************
	logic        pin_b_meta_r;
	logic        pin_b_sync_r;

	// Two stages before any logic reads the pin
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			pin_b_meta_r <= 1'b0;
			pin_b_sync_r <= 1'b0;
		end else begin
			pin_b_meta_r <= osc_pin_b_in;
			pin_b_sync_r <= pin_b_meta_r;
		end
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			trim_r   <= trim_type'(7'(`TRIM_RESET));
			ctrl_r   <= `CTRL_RESET;
			pready   <= 1'b0;
			pslverr  <= 1'b0;
			prdata   <= 32'h0;
			wr_ack_r <= 1'b0;
		end else begin
			pready   <= access & !pready;
			pslverr  <= access & !pready & unmapped;
			prdata   <= (access & !pready & !pwrite) ? rdata_nxt : 32'h0;
			wr_ack_r <= wr_trim;
			if (wr_trim)
				trim_r <= trim_nxt;
			else if (!pll_allowed)
				trim_r.pll_en <= 1'b0;
			if (wr_ctrl)
				ctrl_r <= pwdata[7:0];
		end
	end

	// Bit 5 reads zero; status word holds no completion flag
	always_comb begin
		rdata_nxt = 32'h0;
		if (hit_trim)
			rdata_nxt = {24'h0, trim_r.src_sel, trim_r.pll_en, 1'b0, trim_r.trim};
		else if (hit_ctrl)
			rdata_nxt = {24'h0, ctrl_r};
		else if (hit_stat)
			rdata_nxt = {28'h0, mode_x4, internal_x4_on, fast_internal_source_on, slow_internal_rc_on};
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			st_r     <= ST_IDLE;
			dly_r    <= 4'h0;
			settle_r <= 18'h0;
			gen_r    <= trim_type'(7'(`TRIM_RESET));
		end else begin
			unique case (st_r)
				ST_IDLE: if (wr_ack_r) begin
					st_r  <= ST_WAIT;
					dly_r <= 4'h0;
				end
				ST_WAIT: begin
					dly_r <= dly_r + 4'h1;
					// Wait for a period boundary, forced by the deadline
					if (gen_period_end || dly_r == `APPLY_DELAY_CYC - 4'h1)
						st_r <= ST_APPLY;
				end
				ST_APPLY: begin
					gen_r    <= trim_r;
					settle_r <= 18'(`SETTLE_CYC);
					st_r     <= wr_ack_r ? ST_WAIT : ST_IDLE;
					dly_r    <= 4'h0;
				end
			endcase
			if (st_r != ST_APPLY && settle_r != 18'h0)
				settle_r <= settle_r - 18'h1;
			if (!pll_allowed)
				gen_r.pll_en <= 1'b0;
		end
	end

	// ************************************************************
	// Clock generator controls and pins
	// ************************************************************
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			osc_pin_b_out           <= 1'b0;
			osc_pin_b_oe            <= 1'b0;
			osc_pin_a_out           <= 1'b0;
			osc_pin_a_oe            <= 1'b0;
			port_a_six_in           <= 1'b0;
			start_wait_skip         <= 1'b0;
			crystal_x4_on           <= 1'b0;
			internal_x4_on          <= 1'b0;
			fast_internal_source_on <= 1'b0;
			slow_internal_rc_on     <= 1'b0;
			low_freq_from_fast      <= 1'b0;
			postscale_tap           <= 3'h0;
			gen_trim                <= 5'h0;
			settling                <= 1'b0;
		end else begin
			osc_pin_b_out   <= pin_b_clock ? 1'b0 : port_a_six_out;
			osc_pin_b_oe    <= pin_b_clock | (pin_b_io & port_a_six_oe);
			osc_pin_a_out   <= port_a_seven_out;
			osc_pin_a_oe    <= pin_a_io & port_a_seven_oe;
			port_a_six_in   <= pin_b_io & pin_b_sync_r;
			start_wait_skip <= mode_ec | mode_ec_io;
			crystal_x4_on   <= mode_x4;
			internal_x4_on  <= gen_r.pll_en & pll_allowed & freq_ok;
			fast_internal_source_on <= int_is_clock &&
				(int_sel != `INTERNAL_FREQ_SELECT_31K || gen_r.src_sel);
			slow_internal_rc_on <= (int_is_clock && int_sel == `INTERNAL_FREQ_SELECT_31K && !gen_r.src_sel) ||
				feature_timer_en || feature_monitor_en ||
				feature_watchdog_en || feature_two_speed_en;
			low_freq_from_fast <= int_sel == `INTERNAL_FREQ_SELECT_31K && gen_r.src_sel;
			postscale_tap   <= int_sel;
			gen_trim        <= gen_r.trim;
			settling        <= settle_r != 18'h0;
		end
	end

	// ************************************************************
	// Checks
	// ************************************************************
	sequence trim_write_s;
		wr_trim;
	endsequence
	sequence applied_s;
		##[1:9] st_r == ST_APPLY;
	endsequence

	a_trim_apply_bound: assert property (@(posedge ref_clk) disable iff (!reset_n)
		trim_write_s |-> applied_s) else $error("trim not applied in time");
	a_pll_forced_zero: assert property (@(posedge ref_clk) disable iff (!reset_n)
		!pll_allowed |=> !trim_r.pll_en) else $error("multiplier enable not forced low");
	a_int_x4_gate: assert property (@(posedge ref_clk) disable iff (!reset_n)
		internal_x4_on |-> $past(freq_ok) && $past(pll_allowed)) else $error("internal multiplier ungated");
	a_xtal_x4_code: assert property (@(posedge ref_clk) disable iff (!reset_n)
		crystal_x4_on |-> $past(osc_config_field) == `CODE_HS_PLL) else $error("crystal multiplier bad code");
	a_bit5_zero: assert property (@(posedge ref_clk) disable iff (!reset_n)
		pready && $past(hit_trim) && !$past(pwrite) |-> prdata[5] == 1'b0) else $error("bit 5 not zero");
	a_pin_b_io: assert property (@(posedge ref_clk) disable iff (!reset_n)
		$past(pin_b_io) |-> osc_pin_b_out == $past(port_a_six_out)) else $error("pin b not port bit");
	a_slow_rc_on: assert property (@(posedge ref_clk) disable iff (!reset_n)
		feature_watchdog_en |=> slow_internal_rc_on) else $error("slow rc not running");
	a_ec_no_wait: assert property (@(posedge ref_clk) disable iff (!reset_n)
		mode_ec |=> start_wait_skip) else $error("start wait not skipped");

endmodule // osc_ctrl

// *** logic/osc_pkg.sv ***
// Types of the clock control block
package osc_pkg;
	typedef struct packed {
		logic       src_sel;
		logic       pll_en;
		logic [4:0] trim;
	} trim_type;
	typedef struct packed {
		logic out_b;
		logic oe_b;
		logic pin_a_io;
		logic pin_b_io;
	} pin_type;
	typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_APPLY} apply_type;
endpackage

// *** sim/oscillator_mode_pll_tuning_test.sv ***
// Self-checking bench for the clock control block
`timescale 1ns/1ps
`include "osc_consts.svh"
module oscillator_mode_pll_tuning_test;
	import osc_pkg::*;
	localparam logic [3:0] md[5] = '{`CODE_EC, `CODE_EC_IO, `CODE_RC, `CODE_RC_IO, `CODE_HS_PLL};
	logic        ref_clk, reset_n, psel, penable, pwrite, pready, pslverr, e;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, q;
	logic [3:0]  osc_config_field;
	logic        feature_timer_en, feature_monitor_en, feature_watchdog_en, feature_two_speed_en;
	logic        gen_period_end, port_a_six_out, port_a_six_oe, port_a_seven_out, port_a_seven_oe;
	logic        osc_pin_b_in, osc_pin_b_out, osc_pin_b_oe, osc_pin_a_out, osc_pin_a_oe, port_a_six_in;
	logic        start_wait_skip, crystal_x4_on, internal_x4_on, fast_internal_source_on;
	logic        slow_internal_rc_on, low_freq_from_fast, settling;
	logic [2:0]  postscale_tap;
	logic [4:0]  gen_trim;
	int          err_count, n_checks;

	osc_ctrl dut (.*);

	always #2.5 ref_clk = ~ref_clk;

	// ****************
	// Bus and check tasks
	// ****************
	task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			$display("BAD %s expected %h seen %h", nm, exp, seen);
			err_count++;
		end
	endtask
	task cyc(input int n);
		repeat (n) @(posedge ref_clk);
	endtask
	task apb(input logic [11:0] a, input logic w, input logic [31:0] d);
		int n;
		@(posedge ref_clk);
		psel <= 1'b1;
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge ref_clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n >= 20) err_count++;
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task rd(input logic [11:0] a, input logic [31:0] x, input string nm);
		apb(a, 1'b0, 32'h0);
		check(nm, q, x);
	endtask
	task rst(input logic [3:0] c);
		reset_n <= 1'b0;
		osc_config_field <= c;
		cyc(8);
		reset_n <= 1'b1;
		cyc(4);
	endtask
	task results;
		if (err_count == 0 && n_checks > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask

	// ****************
	// Test sequence
	// ****************
	initial begin
		ref_clk = 0;
		reset_n = 0;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		{feature_timer_en, feature_monitor_en, feature_watchdog_en, feature_two_speed_en} = 4'h0;
		{gen_period_end, port_a_six_out, port_a_six_oe} = 3'h0;
		{port_a_seven_out, port_a_seven_oe, osc_pin_b_in} = 3'h7;
		osc_config_field = 4'h9;
		err_count = 0;
		n_checks = 0;
		rst(4'h9);
		rd(`TRIM_REG_ADDR, 32'h0, "trim reset");
		rd(`CTRL_REG_ADDR, 32'h40, "ctrl reset");
		check("tap reset", postscale_tap, 3'h4);
		check("pin a oe", osc_pin_a_oe, 1'b1);
		check("pin a out", osc_pin_a_out, 1'b1);
		check("pin b oe", osc_pin_b_oe, 1'b1);
		apb(`TRIM_REG_ADDR, 1'b1, 32'hff);
		rd(`TRIM_REG_ADDR, 32'hdf, "trim bits");
		for (int f = 0; f < 8; f++) begin
			apb(`CTRL_REG_ADDR, 1'b1, 32'(f << 4));
			cyc(3);
			check("tap", postscale_tap, f);
			check("int x4", internal_x4_on, f >= 6);
			check("from fast", low_freq_from_fast, f == 0);
			if (f > 0) check("fast on", fast_internal_source_on, 1'b1);
		end
		apb(`TRIM_REG_ADDR, 1'b1, 32'h0f);
		cyc(10);
		check("trim max", gen_trim, 5'h0f);
		check("settling", settling, 1'b1);
		check("x4 off", internal_x4_on, 1'b0);
		rd(`STAT_REG_ADDR, 32'h2, "status");
		apb(`TRIM_REG_ADDR, 1'b1, 32'h10);
		cyc(10);
		check("trim min", gen_trim, 5'h10);
		apb(`TRIM_REG_ADDR, 1'b1, 32'h05);
		gen_period_end <= 1'b1;
		cyc(1);
		gen_period_end <= 1'b0;
		cyc(3);
		check("safe point", gen_trim, 5'h05);
		apb(`CTRL_REG_ADDR, 1'b1, 32'h0);
		cyc(3);
		check("slow sel", slow_internal_rc_on, 1'b1);
		check("slow src", low_freq_from_fast, 1'b0);
		apb(`CTRL_REG_ADDR, 1'b1, 32'h70);
		for (int i = 0; i < 5; i++) begin
			{feature_timer_en, feature_monitor_en, feature_watchdog_en, feature_two_speed_en} <= 4'(1 << i);
			cyc(3);
			check("slow feat", slow_internal_rc_on, i < 4);
		end
		apb(12'h00c, 1'b1, 32'h55);
		check("bad wr err", e, 1'b1);
		rd(12'h00c, 32'h0, "bad rd");
		check("bad rd err", e, 1'b1);
		rst(4'h8);
		check("two a oe", osc_pin_a_oe, 1'b1);
		check("two b oe", osc_pin_b_oe, 1'b0);
		check("two six in", port_a_six_in, 1'b1);
		apb(`TRIM_REG_ADDR, 1'b1, 32'h40);
		rd(`TRIM_REG_ADDR, 32'h40, "enable kept");
		for (int i = 0; i < 5; i++) begin
			rst(md[i]);
			apb(`TRIM_REG_ADDR, 1'b1, 32'h40);
			rd(`TRIM_REG_ADDR, 32'h0, "forced enable");
			check("skip", start_wait_skip, i < 2);
			if (i < 4) check("b oe", osc_pin_b_oe, i == 0 || i == 2);
			if (i == 1 || i == 3) check("six in", port_a_six_in, 1'b1);
			check("crystal x4", crystal_x4_on, i == 4);
			check("int x4 off", internal_x4_on, 1'b0);
		end
		results;
	end

	initial begin
		cyc(20000);
		err_count++;
		results;
	end
endmodule // oscillator_mode_pll_tuning_test
